// *** core/spim_top.sv ***
// Standalone process image mapper: shift-register expansion, analog unit,
// link-side image ports, reset filter and bus indicators.
// Assumes the link stack and converters are outside; all pins synchronous.
//
// What this block does
// - Two analog channels converted to 12 bits, each up to 100 kS/s.
// - One analog output driven from a 10-bit code at up to 100 kS/s.
// - Link runs at 38.4 kBaud or 230.4 kBaud.
// - A reset pin low for 50 ns or longer requests a reset.
// - Reset restores defaults, reboots and re-reads start-up configuration.
// - Reset pin has a pull-up; an open pin means normal running.
// - Shift cycle and exchange length follow configured byte counts, not fitted parts.
// - Analog enabled: input bytes 0-3 analog, 28 digital in, 32 out.
// - Analog disabled: 32 digital input bytes and 32 output bytes.
// - Analog layout: first channel bytes 0-1, second 2-3, inputs from byte 4.
// - Without analog, input byte 0 holds inputs 1-8, up to byte 31.
// - Output byte 0 drives outputs 1-8, up to byte 31.
// - Image bit order equals the order seen by the link master.
// - Two indicator outputs: bus healthy and bus fault.
// - Link detects undervoltage, short and overtemperature; overtemperature shuts it down.
// - Cycle: input latch pulse, joint shift, then output latch pulse.
// - Serial data both ways moves most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module spim_top
    import spim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reset_request_n,
    input wire spim_cfg_s cfg_straps,
    // Serial shift expansion
    output logic shift_clk,
    output logic input_latch_strobe,
    output logic output_latch_strobe,
    output logic shift_serial_out,
    input wire logic shift_serial_in,
    // Converters
    output logic adc_start,
    output logic adc_channel,
    input wire logic adc_done,
    input wire logic [ADC_BITS-1:0] adc_result,
    input wire logic [DAC_BITS-1:0] dac_code_req,
    output logic [DAC_BITS-1:0] analog_output_line,
    output logic dac_update,
    // Link stack side
    input wire logic [IMG_AW-1:0] pd_in_addr,
    output logic [7:0] pd_in_data,
    input wire logic pd_out_we,
    input wire logic [IMG_AW-1:0] pd_out_addr,
    input wire logic [7:0] pd_out_data,
    output logic [5:0] pd_in_len,
    output logic [5:0] pd_out_len,
    output logic link_baud_tick,
    output logic link_fast_baud,
    input wire logic link_tx_bit,
    input wire logic link_tx_en,
    output logic link_rx_bit,
    input wire spim_link_stat_s link_stat,
    output logic link_shutdown,
    // Field link data pin
    input wire logic field_link_data_line_i,
    output logic field_link_data_line_o,
    output logic field_link_data_line_oe,
    // Indicators
    output logic bus_ok_indicator,
    output logic bus_fault_indicator
);
    // ==========================================================
    // Reset request filter
    logic [2:0] low_count;
    logic ext_reset;
    // An open pin reads high thanks to the board pull-up
    wire pin_low = !reset_request_n;
    wire core_rst = !resetn || ext_reset;

    always_ff @(posedge clk_sys) begin
        if (!resetn || !pin_low) begin
            low_count <= '0;
        end else if (low_count != 3'(RESET_SEEN_CYC)) begin
            low_count <= low_count + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ext_reset <= 1'b0;
        end else begin
            ext_reset <= pin_low && (low_count + 3'h1 >= 3'(RESET_SEEN_CYC));
        end
    end

    // ==========================================================
    // Start-up configuration and clamping
    spim_state_e state, next_state;
    spim_cfg_s cfg;
    wire [5:0] dig_in_cap = cfg.analog_en ? MAX_DIG_IN_ANA : MAX_BYTES;
    wire [5:0] dig_in_bytes = (cfg.in_bytes > dig_in_cap) ? dig_in_cap : cfg.in_bytes;
    wire [5:0] out_bytes = (cfg.out_bytes > MAX_BYTES) ? MAX_BYTES : cfg.out_bytes;
    wire [5:0] ana_bytes = cfg.analog_en ? 6'(ANA_BYTES) : 6'h00;
    wire [5:0] chain_bytes = (dig_in_bytes > out_bytes) ? dig_in_bytes : out_bytes;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            cfg <= '0;
        end else if (state == ST_BOOT) begin
            cfg <= cfg_straps; // Straps re-read on every boot
        end
    end

    // Exchange length set by configuration only
    assign pd_in_len = ana_bytes + dig_in_bytes;
    assign pd_out_len = out_bytes;

    // ==========================================================
    // Shift engine
    logic [5:0] byte_idx;
    logic [2:0] bit_idx;
    logic [7:0] tx_byte, rx_byte;
    logic [7:0] out_q, in_q;
    logic half_tick;

    spim_tick_div u_shift_div (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .en(state != ST_BOOT),
        .period(SHIFT_HALF_CYC),
        .tick(half_tick)
    );

    // Offset 0 travels last so that it ends in the nearest register
    wire [5:0] slot_rev = chain_bytes - 6'h1 - byte_idx;
    wire [IMG_AW-1:0] slot_addr = slot_rev[IMG_AW-1:0];
    wire slot_has_out = slot_rev < out_bytes;
    wire slot_has_in = slot_rev < dig_in_bytes;
    wire last_byte = (byte_idx + 6'h1 >= chain_bytes);
    wire in_we = (state == ST_STORE) && slot_has_in;

    always_comb begin
        next_state = state;
        case (state)
            ST_BOOT: next_state = ST_IDLE;
            ST_IDLE: next_state = (half_tick && chain_bytes != 6'h00) ? ST_LOAD_IN : ST_IDLE;
            ST_LOAD_IN: next_state = (half_tick && input_latch_strobe) ? ST_FETCH : ST_LOAD_IN;
            ST_FETCH: next_state = ST_LOAD_TX;
            ST_LOAD_TX: next_state = ST_SHIFT;
            ST_SHIFT: next_state = (half_tick && shift_clk && bit_idx == 3'h7) ?
                                   ST_STORE : ST_SHIFT;
            ST_STORE: next_state = last_byte ? ST_LOAD_OUT : ST_FETCH;
            ST_LOAD_OUT: next_state = (half_tick && output_latch_strobe) ? ST_IDLE : ST_LOAD_OUT;
            default: next_state = ST_BOOT;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            state <= ST_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // Input latch: low loads the parallel inputs, high holds them
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            input_latch_strobe <= 1'b1;
            output_latch_strobe <= 1'b0;
        end else begin
            // Falls on entry, rises one tick later, so shifting never sees it low
            if (next_state == ST_LOAD_IN && half_tick) begin
                input_latch_strobe <= !input_latch_strobe;
            end
            if (state == ST_LOAD_OUT && half_tick) begin // Rising edge applies outputs
                output_latch_strobe <= !output_latch_strobe;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst || state == ST_IDLE) begin
            byte_idx <= '0;
        end else if (state == ST_STORE) begin
            byte_idx <= byte_idx + 6'h1;
        end
    end

    // One clock moves input and output together, MSB first
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            shift_clk <= 1'b0;
            bit_idx <= '0;
            tx_byte <= '0;
            rx_byte <= '0;
        end else if (state == ST_LOAD_TX) begin
            tx_byte <= slot_has_out ? out_q : 8'h00;
            bit_idx <= '0;
        end else if (state == ST_SHIFT && half_tick) begin
            shift_clk <= !shift_clk;
            if (!shift_clk) begin
                rx_byte <= {rx_byte[6:0], shift_serial_in};
            end else begin
                tx_byte <= {tx_byte[6:0], 1'b0};
                bit_idx <= bit_idx + 3'h1;
            end
        end
    end

    assign shift_serial_out = tx_byte[7];

    // ==========================================================
    // Process images
    // Unfitted registers leave whatever the open line gives
    spim_image_ram u_in_img (
        .clk_sys(clk_sys),
        .we(in_we),
        .waddr(slot_addr),
        .wdata(rx_byte),
        .raddr(pd_in_addr - IMG_AW'(ana_bytes)),
        .rdata(in_q)
    );

    // Output byte n bit k drives output 8n+k+1 unchanged
    spim_image_ram u_out_img (
        .clk_sys(clk_sys),
        .we(pd_out_we),
        .waddr(pd_out_addr),
        .wdata(pd_out_data),
        .raddr(slot_addr),
        .rdata(out_q)
    );

    // ==========================================================
    // Analog unit
    logic [ADC_BITS-1:0] an_first, an_second;
    logic adc_slot, dac_tick;
    logic [7:0] ana_q;
    logic use_ana;

    spim_tick_div u_adc_div (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .en(cfg.analog_en),
        .period(ADC_SLOT_CYC),
        .tick(adc_slot)
    );

    spim_tick_div u_dac_div (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .en(cfg.analog_en),
        .period(DAC_CYC),
        .tick(dac_tick)
    );

    // Alternating slots give each channel 100 kS/s
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            adc_start <= 1'b0;
            adc_channel <= 1'b0;
            an_first <= '0;
            an_second <= '0;
        end else begin
            adc_start <= adc_slot;
            if (adc_slot) begin
                adc_channel <= !adc_channel;
            end
            if (adc_done && adc_channel) begin
                an_first <= adc_result;
            end else if (adc_done) begin
                an_second <= adc_result;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            analog_output_line <= '0;
            dac_update <= 1'b0;
        end else begin
            dac_update <= dac_tick;
            if (dac_tick) begin
                analog_output_line <= dac_code_req;
            end
        end
    end

    // Right-aligned results, high byte top bits zero
    wire ana_hit = cfg.analog_en && (pd_in_addr < IMG_AW'(ANA_BYTES));
    wire [7:0] ana_sel = (pd_in_addr == OFS_AN_FIRST_HI) ? 8'(an_first >> 8) :
                         (pd_in_addr == OFS_AN_FIRST_LO) ? an_first[7:0] :
                         (pd_in_addr == OFS_AN_SECOND_HI) ? 8'(an_second >> 8) :
                         an_second[7:0];

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            ana_q <= '0;
            use_ana <= 1'b0;
        end else begin
            ana_q <= ana_sel;
            use_ana <= ana_hit;
        end
    end

    // Digital bytes follow the analog ones, or start at 0
    assign pd_in_data = use_ana ? ana_q : in_q;

    // ==========================================================
    // Link pin, rate and protection
    wire link_fault = link_stat.undervolt || link_stat.short_circuit ||
                      link_stat.overtemp || link_shutdown;

    spim_tick_div u_baud_div (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .en(state != ST_BOOT),
        .period(cfg.fast_baud ? BAUD_FAST_CYC : BAUD_SLOW_CYC),
        .tick(link_baud_tick)
    );

    // Thermal shutdown holds until the next reset
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            link_shutdown <= 1'b0;
            bus_ok_indicator <= 1'b0;
            bus_fault_indicator <= 1'b0;
        end else begin
            if (link_stat.overtemp) begin
                link_shutdown <= 1'b1;
            end
            bus_ok_indicator <= link_stat.comm_ok && !link_fault;
            bus_fault_indicator <= link_fault;
        end
    end

    assign link_fast_baud = cfg.fast_baud;
    assign field_link_data_line_o = link_tx_bit;
    assign field_link_data_line_oe = link_tx_en && !link_shutdown;
    assign link_rx_bit = field_link_data_line_i;
endmodule
`default_nettype wire

// *** core/spim_pkg.sv ***
// Shared constants and carriers of the standalone process image mapper.
// Assumes one 50 MHz system clock; all rates below are derived from it.
package spim_pkg;

    // ==========================================================
    // Clock and reset timing
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 50;
    // Edges that are sure to see a pulse of the least width
    localparam int RESET_SEEN_CYC = (RESET_MIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    RESET_MIN_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Process image layout
    localparam int IMG_BYTES = 32;
    localparam int IMG_AW = 5;
    localparam int ANA_BYTES = 4;
    localparam int ADC_BITS = 12;
    localparam int DAC_BITS = 10;
    localparam logic [IMG_AW-1:0] OFS_AN_FIRST_HI = 5'h00;
    localparam logic [IMG_AW-1:0] OFS_AN_FIRST_LO = 5'h01;
    localparam logic [IMG_AW-1:0] OFS_AN_SECOND_HI = 5'h02;
    localparam logic [IMG_AW-1:0] OFS_AN_SECOND_LO = 5'h03;
    localparam logic [5:0] MAX_BYTES = 6'h20;
    localparam logic [5:0] MAX_DIG_IN_ANA = 6'h1c;

    // ==========================================================
    // Rates turned into cycle counts
    localparam int DIV_W = 11;
    localparam int ADC_RATE_SPS = 100_000;
    localparam int DAC_RATE_SPS = 100_000;
    localparam int BAUD_SLOW = 38_400;
    localparam int BAUD_FAST = 230_400;
    localparam int SHIFT_BPS = 5_000_000;
    // Two channels share the converter, so slots come twice as often
    localparam logic [DIV_W-1:0] ADC_SLOT_CYC = DIV_W'(CLK_HZ / (2 * ADC_RATE_SPS));
    localparam logic [DIV_W-1:0] DAC_CYC = DIV_W'(CLK_HZ / DAC_RATE_SPS);
    localparam logic [DIV_W-1:0] BAUD_SLOW_CYC = DIV_W'(CLK_HZ / BAUD_SLOW);
    localparam logic [DIV_W-1:0] BAUD_FAST_CYC = DIV_W'(CLK_HZ / BAUD_FAST);
    localparam logic [DIV_W-1:0] SHIFT_HALF_CYC = DIV_W'(CLK_HZ / (2 * SHIFT_BPS));

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic analog_en;
        logic fast_baud;
        logic [5:0] in_bytes;
        logic [5:0] out_bytes;
    } spim_cfg_s;

    typedef struct packed {
        logic comm_ok;
        logic undervolt;
        logic short_circuit;
        logic overtemp;
    } spim_link_stat_s;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_LOAD_IN = 3'b010,
        ST_FETCH = 3'b011,
        ST_LOAD_TX = 3'b100,
        ST_SHIFT = 3'b101,
        ST_STORE = 3'b110,
        ST_LOAD_OUT = 3'b111
    } spim_state_e;

endpackage

// *** core/spim_tick_div.sv ***
// Programmable divider giving a one-cycle enable pulse every period cycles.
// Assumes period is at least 1 and held stable while enabled.
`timescale 1ns/1ps
`default_nettype none
module spim_tick_div
    import spim_pkg::*;
#(
    parameter int W = DIV_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] count;
    wire last = (count >= period - W'(1));

    always_ff @(posedge clk_sys) begin
        if (rst || !en || last) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    assign tick = en && last;
endmodule
`default_nettype wire

// *** core/spim_image_ram.sv ***
// Small process image store: one write port, one read port, registered read.
// Assumes both ports on the system clock; a read of the address being
// written returns the old byte.
`timescale 1ns/1ps
`default_nettype none
module spim_image_ram
    import spim_pkg::*;
#(
    parameter int DEPTH = IMG_BYTES,
    parameter int AW = IMG_AW
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    // No reset on the array: the owner sends unused output slots as zero
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// *** verification/spim_shift_chain.sv ***
// Behavioural chain of external parallel-in and parallel-out shift registers.
// Assumes strobes and shift clock come from the mapper; NB bytes are fitted.
`timescale 1ns/1ps
`default_nettype none
module spim_shift_chain #(
    parameter int NB = 4
) (
    input wire logic shift_clk,
    input wire logic input_latch_strobe,
    input wire logic output_latch_strobe,
    input wire logic shift_serial_out,
    output logic shift_serial_in,
    input wire logic [8*NB-1:0] par_in,
    output logic [8*NB-1:0] par_out
);
    logic [8*NB-1:0] in_sr;
    logic [8*NB-1:0] out_sr;

    // ==========================================================
    // Input parts
    // Transparent while the strobe is low, frozen for shifting while high
    // Open chain tail is pulled up, so surplus bits read as ones
    always @(posedge shift_clk or negedge input_latch_strobe or par_in)
        if (!input_latch_strobe) in_sr <= par_in;
        else if (shift_clk) in_sr <= {in_sr[8*NB-2:0], 1'b1};
    assign shift_serial_in = in_sr[8*NB-1];

    // ==========================================================
    // Output parts
    always @(posedge shift_clk) out_sr <= {out_sr[8*NB-2:0], shift_serial_out};
    always @(posedge output_latch_strobe) par_out <= out_sr;
endmodule
`default_nettype wire

// *** verification/spim_top_sva.sv ***
// Port checker of the process image mapper, bound into spim_top.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module spim_top_sva
    import spim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reset_request_n,
    input wire logic shift_clk,
    input wire logic input_latch_strobe,
    input wire logic output_latch_strobe,
    input wire logic adc_start,
    input wire logic dac_update,
    input wire logic link_tx_bit,
    input wire logic link_tx_en,
    input wire logic link_rx_bit,
    input wire spim_link_stat_s link_stat,
    input wire logic link_shutdown,
    input wire logic field_link_data_line_i,
    input wire logic field_link_data_line_o,
    input wire logic field_link_data_line_oe,
    input wire logic bus_ok_indicator,
    input wire logic bus_fault_indicator
);
    // ==========================================================
    // Helpers
    // Pin reset counts as over only after four quiet samples
    logic [2:0] pin_hist;
    logic quiet;
    always_ff @(posedge clk_sys)
        if (!resetn) pin_hist <= 3'h7;
        else pin_hist <= {pin_hist[1:0], reset_request_n};
    assign quiet = reset_request_n && (pin_hist == 3'h7);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !quiet);

    // ==========================================================
    // Assertions
    AST_LIN_LOW: assert property ($fell(input_latch_strobe) |-> !input_latch_strobe [*5])
        else $error("input latch low too short");
    AST_OUTPUT_LATCH_STROBE_PULSE: assert property ($rose(output_latch_strobe) |->
        output_latch_strobe [*5] ##1 !output_latch_strobe) else $error("output latch width");
    AST_NO_CLK_IN_LATCH: assert property ((!input_latch_strobe || output_latch_strobe) |->
        !shift_clk) else $error("shift clock during latch");
    AST_CLK_PHASE: assert property ($rose(shift_clk) |-> shift_clk [*5] ##1 !shift_clk)
        else $error("shift clock phase");
    AST_RESET_IDLE: assert property (disable iff (1'b0) !resetn |=> input_latch_strobe
        && !output_latch_strobe && !shift_clk && !bus_ok_indicator && !link_shutdown)
        else $error("not idle in reset");
    AST_PIN_RESET: assert property (disable iff (!resetn) !reset_request_n &&
        $past(!reset_request_n) |-> ##[1:3] !bus_ok_indicator) else $error("pin reset ignored");
    AST_FAULT_LAMP: assert property ((link_stat.undervolt || link_stat.short_circuit ||
        link_stat.overtemp) |-> ##[1:3] bus_fault_indicator) else $error("fault lamp off");
    AST_LAMPS_EXCL: assert property (bus_ok_indicator |-> !bus_fault_indicator)
        else $error("both lamps lit");
    AST_THERMAL: assert property (link_stat.overtemp |-> ##[1:3] link_shutdown)
        else $error("no thermal shutdown");
    AST_STICKY: assert property (link_shutdown |=> link_shutdown)
        else $error("shutdown released");
    AST_PIN_DRIVE: assert property (field_link_data_line_oe == (link_tx_en && !link_shutdown)
        && (!link_tx_en || field_link_data_line_o == link_tx_bit)) else $error("pin drive");
    AST_RX_PATH: assert property (link_rx_bit == field_link_data_line_i)
        else $error("receive path");
    AST_ADC_SPACING: assert property (adc_start |=> !adc_start [*8])
        else $error("converter starts too close");

    COV_CYCLE: cover property ($rose(output_latch_strobe));
    COV_SHUTDOWN: cover property ($rose(link_shutdown));
    COV_DAC: cover property (dac_update);
endmodule

bind spim_top spim_top_sva i_spim_top_sva (.clk_sys(clk_sys), .resetn(resetn),
    .reset_request_n(reset_request_n), .shift_clk(shift_clk),
    .input_latch_strobe(input_latch_strobe), .output_latch_strobe(output_latch_strobe),
    .adc_start(adc_start), .dac_update(dac_update), .link_tx_bit(link_tx_bit),
    .link_tx_en(link_tx_en), .link_rx_bit(link_rx_bit), .link_stat(link_stat),
    .link_shutdown(link_shutdown), .field_link_data_line_i(field_link_data_line_i),
    .field_link_data_line_o(field_link_data_line_o),
    .field_link_data_line_oe(field_link_data_line_oe),
    .bus_ok_indicator(bus_ok_indicator), .bus_fault_indicator(bus_fault_indicator));
`default_nettype wire

// *** verification/spim_top_bench.sv ***
// Self-checking bench of the process image mapper and a four-byte chain.
// Assumes the converters and the link master are stood in for inline.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module spim_top_bench;
    import spim_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic reset_request_n = 1'b1;
    spim_cfg_s cfg_straps = '0;
    logic shift_clk, input_latch_strobe, output_latch_strobe, shift_serial_out;
    logic shift_serial_in, adc_start, adc_channel, dac_update, link_baud_tick;
    logic link_fast_baud, link_rx_bit, link_shutdown, bus_ok_indicator, bus_fault_indicator;
    logic field_link_data_line_i, field_link_data_line_o, field_link_data_line_oe;
    logic adc_done = 1'b0;
    logic [ADC_BITS-1:0] adc_result = '0;
    logic [DAC_BITS-1:0] dac_code_req = '0;
    logic [DAC_BITS-1:0] analog_output_line;
    logic [IMG_AW-1:0] pd_in_addr = '0;
    logic [IMG_AW-1:0] pd_out_addr = '0;
    logic [7:0] pd_in_data;
    logic [7:0] pd_out_data = '0;
    logic pd_out_we = 1'b0;
    logic [5:0] pd_in_len, pd_out_len;
    logic link_tx_bit = 1'b0;
    logic link_tx_en = 1'b0;
    spim_link_stat_s link_stat = '0;
    logic master_drv = 1'b1;
    logic [31:0] par_in = '0;
    logic [31:0] par_out;
    logic [1:0] adc_pipe = '0;
    int n_errors = 0;
    int n_compared = 0;
    int n_sclk = 0;
    localparam logic [11:0] AN_A = 12'habc;
    localparam logic [11:0] AN_B = 12'h123;

    always #10 clk_sys = ~clk_sys;
    // Device wins the pin while enabled, the master drives it otherwise
    assign field_link_data_line_i = field_link_data_line_oe ? field_link_data_line_o : master_drv;
    // Converter stand-in answers three cycles after each start
    always @(posedge clk_sys) begin
        adc_pipe <= {adc_pipe[0], adc_start};
        adc_done <= adc_pipe[1];
        adc_result <= adc_channel ? AN_A : AN_B;
    end
    always @(posedge shift_clk) n_sclk++;
    always @(negedge input_latch_strobe) n_sclk = 0;

    spim_top i_spim_top (.*);
    spim_shift_chain #(.NB(4)) i_spim_shift_chain (.*);

    // ==========================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic boot(input spim_cfg_s c);
        @(posedge clk_sys);
        cfg_straps <= c;
        resetn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask
    task automatic rd(input logic [IMG_AW-1:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        pd_in_addr <= a;
        cyc(1);
        `CHK(pd_in_data, exp)
    endtask
    task automatic wr(input logic [IMG_AW-1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        pd_out_we <= 1'b1;
        pd_out_addr <= a;
        pd_out_data <= d;
        @(posedge clk_sys);
        pd_out_we <= 1'b0;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? link_baud_tick : (w == 1 ? adc_start : dac_update);
    endfunction
    // Cycles between two pulses of the chosen output
    task automatic gap(input int w, input int exp);
        int i;
        i = 0;
        while (pick(w) !== 1'b1 && i < 3000) begin cyc(1); i++; end
        i = 0;
        do begin cyc(1); i++; end while (pick(w) !== 1'b1 && i < 3000);
        `CHK(i, exp)
    endtask
    task automatic wait_output_latch_strobe();
        int i;
        i = 0;
        while (output_latch_strobe !== 1'b0 && i < 3000) begin cyc(1); i++; end
        while (output_latch_strobe !== 1'b1 && i < 3000) begin cyc(1); i++; end
        `CHK(i < 3000, 1'b1)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_digital();
        logic [31:0] img;
        img = 32'h970f_e13d;
        boot('{1'b0, 1'b0, 6'h04, 6'h04});
        par_in <= 32'h1e46_c86d;
        for (int k = 0; k < 4; k++) wr(k[IMG_AW-1:0], img[8*k+:8]);
        repeat (2) wait_output_latch_strobe();
        `CHK(par_out, img)
        `CHK(n_sclk, 32)
        for (int k = 0; k < 4; k++) rd(k[IMG_AW-1:0], par_in[8*k+:8]);
        gap(0, 1302);
    endtask
    task automatic t_length();
        boot('{1'b0, 1'b0, 6'h02, 6'h06});
        repeat (2) wait_output_latch_strobe();
        `CHK(n_sclk, 48)
        `CHK({pd_in_len, pd_out_len}, {6'h02, 6'h06})
    endtask
    task automatic t_analog();
        boot('{1'b1, 1'b1, 6'h08, 6'h04});
        dac_code_req <= 10'h2a5;
        cyc(600);
        rd(5'h00, {4'h0, AN_A[11:8]});
        rd(5'h01, AN_A[7:0]);
        rd(5'h02, {4'h0, AN_B[11:8]});
        rd(5'h03, AN_B[7:0]);
        gap(1, 250);
        gap(0, 217);
        gap(2, 500);
        `CHK({link_fast_baud, analog_output_line}, {1'b1, 10'h2a5})
    endtask
    task automatic t_link();
        boot('{1'b0, 1'b0, 6'h01, 6'h01});
        link_stat <= '{1'b1, 1'b0, 1'b0, 1'b0};
        link_tx_en <= 1'b1;
        cyc(4);
        `CHK({bus_ok_indicator, bus_fault_indicator, link_rx_bit}, 3'b100)
        @(posedge clk_sys);
        link_stat <= '{1'b1, 1'b1, 1'b0, 1'b0};
        link_tx_en <= 1'b0;
        cyc(4);
        `CHK({bus_ok_indicator, bus_fault_indicator, link_rx_bit}, 3'b011)
        @(posedge clk_sys);
        link_stat <= '{1'b1, 1'b0, 1'b0, 1'b1};
        link_tx_en <= 1'b1;
        cyc(4);
        `CHK({link_shutdown, field_link_data_line_oe}, 2'b10)
        @(posedge clk_sys);
        link_stat <= '{1'b1, 1'b0, 1'b0, 1'b0};
        cyc(4);
        `CHK({link_shutdown, bus_fault_indicator}, 2'b11)
        @(posedge clk_sys);
        reset_request_n <= 1'b0;
        @(posedge clk_sys);
        reset_request_n <= 1'b1;
        cyc(6);
        `CHK(link_shutdown, 1'b1)
        @(posedge clk_sys);
        reset_request_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_request_n <= 1'b1;
        cyc(8);
        `CHK({link_shutdown, bus_ok_indicator, bus_fault_indicator}, 3'b010)
    endtask

    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        boot('0);
        t_digital();
        t_length();
        t_analog();
        t_link();
        end_of_test();
    end
    // Whole run needs well under 20000 cycles
    initial begin
        #(20 * 20000);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
